// file: common/phymc_consts.vh
`ifndef PHYMC_CONSTS_VH
`define PHYMC_CONSTS_VH

// ***************************************************************
// register indices (byte address is four times the index)
// ***************************************************************
`define PHYMC_IDX_MODE       6'h15
`define PHYMC_IDX_PLL        6'h17
`define PHYMC_IDX_RXE        6'h18

// ***************************************************************
// mode_control field positions
// ***************************************************************
`define PHYMC_B_FORCE10      14
`define PHYMC_B_FORCE100     13
`define PHYMC_B_JABBER_OFF   12
`define PHYMC_B_SEVEN_WIRE   11
`define PHYMC_B_ACT_RX_ONLY  10
`define PHYMC_B_LED_SCHEME   9
`define PHYMC_B_FAR_OFF      8
`define PHYMC_B_FAR_SEND     7
`define PHYMC_B_RXE_FULL     6
`define PHYMC_B_RXE_OFF      5
`define PHYMC_B_WDOG_OFF     4
`define PHYMC_B_RLOOP        3
`define PHYMC_B_SCRAM        2
`define PHYMC_B_BYPASS       1
`define PHYMC_B_FIBER        0

// ***************************************************************
// masks and reset values
// ***************************************************************
`define PHYMC_MODE_WMASK     16'h7FBF
`define PHYMC_MODE_SMASK     16'h0307
`define PHYMC_MODE_RST       16'h0000
`define PHYMC_CNT_RST        16'h0000
`define PHYMC_CNT_MAX        16'hFFFF
`define PHYMC_CNT_ONE        16'h0001
`define PHYMC_DAT_ZERO       32'h0000_0000

`endif

// file: design/phymc_top.v
// Operation
// [R01] bit 14 forces 10 Mbps link up; local loopback forces it too.
// [R02] bit 13 ignores 100BASE-TX link state and transmits anyway.
// [R03] software sets bit 13 only while the autoneg strap is low; the design has no strap input and accepts bit 13 writes at any time.
// [R04] bit 12 set turns jabber protection off; clear keeps it on.
// [R05] bit 11 selects 7-wire interface, only while bit 1 is clear.
// [R06] advanced LEDs with bit 10 set: activity shows receive only.
// [R07] bit 10 clear: activity is rx or tx in half, rx in full.
// [R08] bit 10 has no effect while basic control duplex bit is one.
// [R09] bit 9 one selects standard LEDs, zero advanced; strap reset.
// [R10] bit 8 clear enables far-end fault; ignored outside fiber mode.
// [R11] bit 7 set sends the far-end-fault pattern unconditionally.
// [R12] bit 6 sets when error tally reaches full; clears on read.
// [R13] bit 5 set stops the receive error tally; clear lets it count.
// [R14] bit 4 set disables the decoder watchdog; clear keeps it.
// [R15] bit 3 set enables remote loopback of media receive data.
// [R16] bit 2 enables scrambling; forced to zero in fiber mode.
// [R17] lock-loss tally counts in 100 Mbps only; writable, resets zero.
// [R18] receive error tally is 16 bits, writable, resets to zero.
// [R19] strap-sourced bits load from sampled strap levels at reset.
// [R20] receive error tally holds at maximum once full until rewritten.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`include "phymc_consts.vh"

module phymc_top #(
   parameter CNT_W = 16
) (
   core_clk,
   rst_n,
   wb_cyc_i,
   wb_stb_i,
   wb_we_i,
   wb_adr_i,
   wb_sel_i,
   wb_dat_i,
   wb_dat_o,
   wb_ack_o,
   led_scheme_strap,
   far_fault_strap,
   scrambler_strap,
   bypass_strap,
   fiber_strap,
   local_loopback,
   nlp_link_ok,
   tx100_link_ok,
   basic_duplex_bit,
   duplex_full,
   rx_activity,
   tx_activity,
   speed_100,
   pll_lock_lost,
   rx_error_event,
   link10_up,
   tx100_enable,
   jabber_enable,
   seven_wire_active,
   activity_led,
   led_standard,
   far_fault_enable,
   far_fault_send,
   watchdog_enable,
   remote_loopback_on,
   scrambler_on,
   coding_sublayer_bypass,
   fiber_mode_select
);
   input  wire              core_clk;               // 100 MHz clock
   input  wire              rst_n;                  // async reset, low
   input  wire              wb_cyc_i;               // bus cycle
   input  wire              wb_stb_i;               // bus strobe
   input  wire              wb_we_i;                // write enable
   input  wire [7:0]        wb_adr_i;               // byte address
   input  wire [3:0]        wb_sel_i;               // byte lanes
   input  wire [31:0]       wb_dat_i;               // write data
   output reg  [31:0]       wb_dat_o;               // read data
   output reg               wb_ack_o;               // acknowledge
   input  wire              led_scheme_strap;       // strap for bit 9
   input  wire              far_fault_strap;        // strap for bit 8
   input  wire              scrambler_strap;        // strap for bit 2
   input  wire              bypass_strap;           // strap for bit 1
   input  wire              fiber_strap;            // strap for bit 0
   input  wire              local_loopback;         // local loopback on
   input  wire              nlp_link_ok;            // link pulses seen
   input  wire              tx100_link_ok;          // 100TX link good
   input  wire              basic_duplex_bit;       // basic control bit 8
   input  wire              duplex_full;            // full duplex now
   input  wire              rx_activity;            // receive activity
   input  wire              tx_activity;            // transmit activity
   input  wire              speed_100;              // 100 Mbps operation
   input  wire              pll_lock_lost;          // lock loss pulse
   input  wire              rx_error_event;         // rx error pulse
   output reg               link10_up;              // 10M link declared
   output reg               tx100_enable;           // 100TX may transmit
   output reg               jabber_enable;          // jabber guard on
   output reg               seven_wire_active;      // 7-wire mode
   output reg               activity_led;           // activity indicator
   output reg               led_standard;           // standard LED scheme
   output reg               far_fault_enable;       // far fault gen/detect
   output reg               far_fault_send;         // send fault pattern
   output reg               watchdog_enable;        // decoder watchdog on
   output reg               remote_loopback_on;     // remote loopback
   output reg               scrambler_on;           // scrambling on
   output reg               coding_sublayer_bypass; // sublayer bypass
   output reg               fiber_mode_select;      // fiber mode

   // ***************************************************************
   // state
   // ***************************************************************
   reg  [15:0]       mode_r;
   reg  [15:0]       mode_nxt;
   reg               full_r;
   reg               full_nxt;
   reg  [CNT_W-1:0]  pll_cnt_r;
   reg  [CNT_W-1:0]  pll_cnt_nxt;
   reg  [CNT_W-1:0]  rxe_cnt_r;
   reg  [CNT_W-1:0]  rxe_cnt_nxt;
   reg               strap_done_r;
   reg  [31:0]       rd_data;
   reg  [15:0]       lane_mask;
   reg  [15:0]       strap_vec;

   wire              bus_req;
   wire              bus_wr;
   wire              bus_rd;
   wire [5:0]        reg_idx;
   wire              hit_mode;
   wire              hit_pll;
   wire              hit_rxe;
   wire              rxe_count;
   wire              rxe_at_max;

   // ***************************************************************
   // bus decode
   // ***************************************************************
   // access completes on the single ack cycle
   assign bus_req  = wb_cyc_i & wb_stb_i & wb_ack_o;
   assign bus_wr   = bus_req & wb_we_i;
   assign bus_rd   = bus_req & ~wb_we_i;
   assign reg_idx  = wb_adr_i[7:2];
   assign hit_mode = (reg_idx == `PHYMC_IDX_MODE);
   assign hit_pll  = (reg_idx == `PHYMC_IDX_PLL);
   assign hit_rxe  = (reg_idx == `PHYMC_IDX_RXE);

   always @* begin
      lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   end

   // one wait state: ack rises the edge after the request and drops the next,
   // so a request held past its ack is acknowledged again two edges later, on every other cycle
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      end
   end

   // unmapped indices read as zero
   always @* begin
      rd_data = `PHYMC_DAT_ZERO;
      if (hit_mode) begin
         rd_data[15:0] = mode_r;
         rd_data[`PHYMC_B_RXE_FULL] = full_r;
      end else if (hit_pll) begin
         rd_data[CNT_W-1:0] = pll_cnt_r;
      end else if (hit_rxe) begin
         rd_data[CNT_W-1:0] = rxe_cnt_r;
      end
   end

   // read data is captured when the ack is raised
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= `PHYMC_DAT_ZERO;
      end else if (wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i) begin
         wb_dat_o <= rd_data;
      end
   end

   // ***************************************************************
   // strap capture
   // ***************************************************************
   // straps are sampled once, on the first edge after reset;
   // from then on the strap-sourced bits belong to software
   always @* begin
      strap_vec = `PHYMC_MODE_RST;
      strap_vec[`PHYMC_B_LED_SCHEME] = led_scheme_strap;
      strap_vec[`PHYMC_B_FAR_OFF]    = far_fault_strap;
      strap_vec[`PHYMC_B_SCRAM]      = scrambler_strap;
      strap_vec[`PHYMC_B_BYPASS]     = bypass_strap;
      strap_vec[`PHYMC_B_FIBER]      = fiber_strap;
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         strap_done_r <= 1'b0;
      end else begin
         strap_done_r <= 1'b1;
      end
   end

   // ***************************************************************
   // mode control register
   // ***************************************************************
   // bits 15 and 6 never take write data; bit 6 reads the live full flag
   always @* begin
      mode_nxt = mode_r;
      if (!strap_done_r) begin
         mode_nxt = (mode_r & ~`PHYMC_MODE_SMASK) | strap_vec; // [R19] [R09]
      end else if (bus_wr & hit_mode) begin
         mode_nxt = (mode_r & ~(lane_mask & `PHYMC_MODE_WMASK))
                  | (wb_dat_i[15:0] & lane_mask & `PHYMC_MODE_WMASK);
      end
      // scrambling cannot stay enabled in fiber mode
      mode_nxt[`PHYMC_B_SCRAM] = mode_nxt[`PHYMC_B_SCRAM] & ~mode_nxt[`PHYMC_B_FIBER]; // [R16]
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_r <= `PHYMC_MODE_RST;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // ***************************************************************
   // receive error tally and full flag
   // ***************************************************************
   // the tally stops at its maximum instead of wrapping, so it stays a lower
   // bound of the errors seen; a software write beats an event
   assign rxe_at_max = (rxe_cnt_r == `PHYMC_CNT_MAX);
   assign rxe_count  = rx_error_event & ~mode_r[`PHYMC_B_RXE_OFF] & ~rxe_at_max; // [R13] [R20]

   always @* begin
      rxe_cnt_nxt = rxe_cnt_r;
      if (bus_wr & hit_rxe) begin
         if (wb_sel_i[0]) begin
            rxe_cnt_nxt[7:0] = wb_dat_i[7:0]; // [R18]
         end
         if (wb_sel_i[1]) begin
            rxe_cnt_nxt[15:8] = wb_dat_i[15:8]; // [R18]
         end
      end else if (rxe_count) begin
         rxe_cnt_nxt = rxe_cnt_r + `PHYMC_CNT_ONE; // [R18]
      end
   end

   always @* begin
      full_nxt = full_r;
      if (bus_rd & hit_mode) begin
         full_nxt = 1'b0; // [R12]
      end
      // a new fill in the clearing cycle still sets the flag
      if (rxe_count & (rxe_cnt_nxt == `PHYMC_CNT_MAX)) begin
         full_nxt = 1'b1; // [R12]
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxe_cnt_r <= `PHYMC_CNT_RST;
         full_r    <= 1'b0;
      end else begin
         rxe_cnt_r <= rxe_cnt_nxt;
         full_r    <= full_nxt;
      end
   end

   // ***************************************************************
   // lock-loss tally
   // ***************************************************************
   // the lock-loss tally wraps; a write in the same cycle drops the event
   always @* begin
      pll_cnt_nxt = pll_cnt_r;
      if (bus_wr & hit_pll) begin
         if (wb_sel_i[0]) begin
            pll_cnt_nxt[7:0] = wb_dat_i[7:0]; // [R17]
         end
         if (wb_sel_i[1]) begin
            pll_cnt_nxt[15:8] = wb_dat_i[15:8]; // [R17]
         end
      end else if (pll_lock_lost & speed_100) begin
         pll_cnt_nxt = pll_cnt_r + `PHYMC_CNT_ONE; // [R17]
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pll_cnt_r <= `PHYMC_CNT_RST;
      end else begin
         pll_cnt_r <= pll_cnt_nxt;
      end
   end

   // ***************************************************************
   // link and transmit control outputs
   // ***************************************************************
   // forcing bit 13 is left to software; the autoneg strap is not seen here
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         link10_up    <= 1'b0;
         tx100_enable <= 1'b0;
      end else begin
         link10_up    <= mode_r[`PHYMC_B_FORCE10] | local_loopback | nlp_link_ok; // [R01]
         tx100_enable <= mode_r[`PHYMC_B_FORCE100] | tx100_link_ok; // [R02]
      end
   end

   // jabber guard and watchdog come up enabled, their safe state
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         jabber_enable     <= 1'b1;
         seven_wire_active <= 1'b0;
         watchdog_enable   <= 1'b1;
      end else begin
         jabber_enable     <= ~mode_r[`PHYMC_B_JABBER_OFF]; // [R04]
         seven_wire_active <= mode_r[`PHYMC_B_SEVEN_WIRE] & ~mode_r[`PHYMC_B_BYPASS]; // [R05]
         watchdog_enable   <= ~mode_r[`PHYMC_B_WDOG_OFF]; // [R14]
      end
   end

   // ***************************************************************
   // indicator outputs
   // ***************************************************************
   // the standard scheme shows any traffic; the advanced one honours bit 10
   // only while the basic control duplex bit is zero
   reg act_nxt;

   always @* begin
      act_nxt = rx_activity | tx_activity;
      if (!mode_r[`PHYMC_B_LED_SCHEME]) begin
         if (mode_r[`PHYMC_B_ACT_RX_ONLY] & ~basic_duplex_bit) begin // [R08]
            act_nxt = rx_activity; // [R06]
         end else if (duplex_full) begin
            act_nxt = rx_activity; // [R07]
         end else begin
            act_nxt = rx_activity | tx_activity; // [R07]
         end
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         activity_led <= 1'b0;
         led_standard <= 1'b0;
      end else begin
         activity_led <= act_nxt;
         led_standard <= mode_r[`PHYMC_B_LED_SCHEME]; // [R09]
      end
   end

   // ***************************************************************
   // fiber, fault, loopback and coding outputs
   // ***************************************************************
   // scrambler_on and far_fault_enable are gated by the fiber bit so a stale bit cannot leak; far_fault_send is not gated
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         far_fault_enable       <= 1'b0;
         far_fault_send         <= 1'b0;
         remote_loopback_on     <= 1'b0;
         scrambler_on           <= 1'b0;
         coding_sublayer_bypass <= 1'b0;
         fiber_mode_select      <= 1'b0;
      end else begin
         far_fault_enable       <= mode_r[`PHYMC_B_FIBER] & ~mode_r[`PHYMC_B_FAR_OFF]; // [R10]
         far_fault_send         <= mode_r[`PHYMC_B_FAR_SEND]; // [R11]
         remote_loopback_on     <= mode_r[`PHYMC_B_RLOOP]; // [R15]
         scrambler_on           <= mode_r[`PHYMC_B_SCRAM] & ~mode_r[`PHYMC_B_FIBER]; // [R16]
         coding_sublayer_bypass <= mode_r[`PHYMC_B_BYPASS];
         fiber_mode_select      <= mode_r[`PHYMC_B_FIBER];
      end
   end

endmodule

// file: sim/phymc_checker.sv
`timescale 1ns/1ps

module phymc_checker #(
   parameter CNT_W = 16
) (
   input wire        core_clk,               // clock
   input wire        rst_n,                  // async reset, low
   input wire        wb_cyc_i,               // bus cycle
   input wire        wb_stb_i,               // bus strobe
   input wire [31:0] wb_dat_o,               // read data
   input wire        wb_ack_o,               // acknowledge
   input wire        local_loopback,         // local loopback on
   input wire        nlp_link_ok,            // link pulses seen
   input wire        tx100_link_ok,          // 100TX link good
   input wire        rx_activity,            // receive activity
   input wire        tx_activity,            // transmit activity
   input wire        link10_up,              // 10M link declared
   input wire        tx100_enable,           // 100TX may transmit
   input wire        activity_led,           // activity indicator
   input wire        far_fault_enable,       // far fault gen/detect
   input wire        fiber_mode_select,      // fiber mode
   input wire        scrambler_on,           // scrambling on
   input wire        seven_wire_active,      // 7-wire mode
   input wire        coding_sublayer_bypass  // sublayer bypass
);
   // ***************************************************************
   // properties
   // ***************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_link_forced_up: assert property ((local_loopback || nlp_link_ok) |=> link10_up)
      else $error("link10_up not raised");
   a_tx100_link_pass: assert property (tx100_link_ok |=> tx100_enable)
      else $error("tx100_enable not raised");
   a_seven_wire_gate: assert property (seven_wire_active |-> !coding_sublayer_bypass)
      else $error("seven wire active during bypass");
   a_rx_lights_led: assert property (rx_activity |=> activity_led)
      else $error("activity_led missed receive activity");
   a_idle_led_dark: assert property ((!rx_activity && !tx_activity) |=> !activity_led)
      else $error("activity_led lit while idle");
   a_far_fault_fiber: assert property (far_fault_enable |-> fiber_mode_select)
      else $error("far fault enabled outside fiber mode");
   a_scram_fiber_off: assert property (fiber_mode_select |-> !scrambler_on)
      else $error("scrambler on in fiber mode");
   a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_follows_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
      else $error("ack not given one cycle after request");
   a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_read_upper_zero: assert property (wb_ack_o |-> (wb_dat_o[31:16] == 16'h0000))
      else $error("read data upper half not zero");
endmodule

bind phymc_top phymc_checker #(.CNT_W(CNT_W)) u_chk (
   .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .local_loopback(local_loopback),
   .nlp_link_ok(nlp_link_ok), .tx100_link_ok(tx100_link_ok), .rx_activity(rx_activity),
   .tx_activity(tx_activity), .link10_up(link10_up), .tx100_enable(tx100_enable),
   .activity_led(activity_led), .far_fault_enable(far_fault_enable),
   .fiber_mode_select(fiber_mode_select), .scrambler_on(scrambler_on),
   .seven_wire_active(seven_wire_active), .coding_sublayer_bypass(coding_sublayer_bypass)
);

// file: sim/tb_top.sv
`timescale 1ns/1ps
`include "phymc_consts.vh"

module tb_top;
   localparam [7:0] A_MODE = {`PHYMC_IDX_MODE, 2'b00};
   localparam [7:0] A_PLL  = {`PHYMC_IDX_PLL, 2'b00};
   localparam [7:0] A_RXE  = {`PHYMC_IDX_RXE, 2'b00};
   reg         core_clk = 1'b0;
   reg         rst_n = 1'b0;
   reg         wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   reg  [7:0]  wb_adr_i = 8'h00;
   reg  [3:0]  wb_sel_i = 4'h0;
   reg  [31:0] wb_dat_i = 32'h0000_0000;
   wire [31:0] wb_dat_o;
   wire        wb_ack_o;
   reg         ll = 1'b0, nlp = 1'b0, t100 = 1'b0, bdup = 1'b0, full = 1'b0;
   reg         rxa = 1'b0, txa = 1'b0, s100 = 1'b0, pll_ev = 1'b0, rxe_ev = 1'b0;
   wire        link10_up, tx100_enable, jabber_enable, seven_wire_active, activity_led;
   wire        led_standard, far_fault_enable, far_fault_send, watchdog_enable;
   wire        remote_loopback_on, scrambler_on, coding_sublayer_bypass, fiber_mode_select;
   reg  [31:0] q;
   reg  [4:0]  strap = 5'b10100;
   reg  [3:0]  lanes = 4'h3;
   integer     num_errors = 0;
   integer     tests_run = 0;

   always #5 core_clk = ~core_clk;

   phymc_top #(.CNT_W(16)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .led_scheme_strap(strap[4]), .far_fault_strap(strap[3]),
      .scrambler_strap(strap[2]), .bypass_strap(strap[1]), .fiber_strap(strap[0]), .local_loopback(ll),
      .nlp_link_ok(nlp), .tx100_link_ok(t100), .basic_duplex_bit(bdup), .duplex_full(full),
      .rx_activity(rxa), .tx_activity(txa), .speed_100(s100), .pll_lock_lost(pll_ev),
      .rx_error_event(rxe_ev), .link10_up(link10_up), .tx100_enable(tx100_enable),
      .jabber_enable(jabber_enable), .seven_wire_active(seven_wire_active),
      .activity_led(activity_led), .led_standard(led_standard),
      .far_fault_enable(far_fault_enable), .far_fault_send(far_fault_send),
      .watchdog_enable(watchdog_enable), .remote_loopback_on(remote_loopback_on),
      .scrambler_on(scrambler_on), .coding_sublayer_bypass(coding_sublayer_bypass),
      .fiber_mode_select(fiber_mode_select)
   );

   // ***************************************************************
   // helper tasks
   // ***************************************************************
   task tally_and_finish;
      if (num_errors == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task check(input [8*12-1:0] nm, input [31:0] seen, input [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         $display("CHECK FAILED %0s expected %h seen %h", nm, exp, seen);
         num_errors = num_errors + 1;
      end
   endtask

   task xfer(input we, input [7:0] adr, input [15:0] d);
      integer k;
      k = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= lanes;
      wb_dat_i <= {16'h0000, d};
      do begin
         @(posedge core_clk);
         k = k + 1;
      end while (wb_ack_o !== 1'b1 && k < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      if (k >= 20) begin
         num_errors = num_errors + 1;
         tally_and_finish;
      end
   endtask

   task settle;
      repeat (3) @(posedge core_clk);
   endtask

   task pulse(input p, input integer n);
      repeat (n) begin
         @(posedge core_clk);
         if (p) pll_ev <= 1'b1;
         else rxe_ev <= 1'b1;
      end
      @(posedge core_clk);
      pll_ev <= 1'b0;
      rxe_ev <= 1'b0;
   endtask

   task act_case(input [15:0] m, input b, input f, input e);
      xfer(1'b1, A_MODE, m);
      bdup <= b;
      full <= f;
      settle;
      check("activity_led", activity_led, e);
   endtask

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      settle;
      check("jabber_en", jabber_enable, 1'b1);
      check("wdog_en", watchdog_enable, 1'b1);
      check("led_std", led_standard, 1'b1);
      check("scram_on", scrambler_on, 1'b1);
      xfer(1'b0, A_MODE, 16'h0000);
      check("mode_rst", q, 32'h0000_0204);
      xfer(1'b0, A_PLL, 16'h0000);
      check("pll_rst", q, 32'h0000_0000);
      xfer(1'b0, A_RXE, 16'h0000);
      check("rxe_rst", q, 32'h0000_0000);
      xfer(1'b1, 8'h40, 16'hFFFF);
      xfer(1'b0, 8'h40, 16'h0000);
      check("unmapped", q, 32'h0000_0000);
      xfer(1'b1, A_MODE, 16'hFFFF);
      xfer(1'b0, A_MODE, 16'h0000);
      check("mode_all", q, 32'h0000_7FBB);
      settle;
      check("jabber_en", jabber_enable, 1'b0);
      check("wdog_en", watchdog_enable, 1'b0);
      check("rloop", remote_loopback_on, 1'b1);
      check("ff_send", far_fault_send, 1'b1);
      check("scram_on", scrambler_on, 1'b0);
      check("seven_wire", seven_wire_active, 1'b0);
      check("ff_enable", far_fault_enable, 1'b0);
      xfer(1'b1, A_MODE, 16'h0801);
      settle;
      check("seven_wire", seven_wire_active, 1'b1);
      check("ff_enable", far_fault_enable, 1'b1);
      txa <= 1'b1;
      act_case(16'h0400, 1'b0, 1'b0, 1'b0);
      act_case(16'h0400, 1'b1, 1'b0, 1'b1);
      act_case(16'h0000, 1'b0, 1'b0, 1'b1);
      act_case(16'h0000, 1'b0, 1'b1, 1'b0);
      check("led_std", led_standard, 1'b0);
      check("ff_enable", far_fault_enable, 1'b0);
      rxa <= 1'b1;
      txa <= 1'b0;
      settle;
      check("activity_led", activity_led, 1'b1);
      rxa <= 1'b0;
      act_case(16'h4000, 1'b0, 1'b0, 1'b0);
      check("link10", link10_up, 1'b1);
      act_case(16'h2000, 1'b0, 1'b0, 1'b0); // forcing bit 13 takes effect at once; the design has no autoneg strap to check
      check("link10", link10_up, 1'b0);
      check("tx100_en", tx100_enable, 1'b1);
      ll <= 1'b1;
      t100 <= 1'b1;
      act_case(16'h0000, 1'b0, 1'b0, 1'b0);
      check("link10", link10_up, 1'b1);
      ll <= 1'b0;
      nlp <= 1'b1;
      pulse(1'b1, 3);
      xfer(1'b0, A_PLL, 16'h0000);
      check("pll_10m", q, 32'h0000_0000);
      s100 <= 1'b1;
      pulse(1'b1, 3);
      xfer(1'b0, A_PLL, 16'h0000);
      check("pll_100m", q, 32'h0000_0003);
      xfer(1'b1, A_PLL, 16'h1234);
      xfer(1'b0, A_PLL, 16'h0000);
      check("pll_write", q, 32'h0000_1234);
      lanes = 4'h1;
      xfer(1'b1, A_PLL, 16'hABCD);
      lanes = 4'h3;
      xfer(1'b0, A_PLL, 16'h0000);
      check("pll_lane", q, 32'h0000_12CD);
      pulse(1'b0, 2);
      xfer(1'b0, A_RXE, 16'h0000);
      check("rxe_count", q, 32'h0000_0002);
      xfer(1'b1, A_MODE, 16'h0020);
      pulse(1'b0, 2);
      xfer(1'b0, A_RXE, 16'h0000);
      check("rxe_off", q, 32'h0000_0002);
      xfer(1'b1, A_MODE, 16'h0000);
      xfer(1'b1, A_RXE, 16'hFFFD);
      pulse(1'b0, 4);
      xfer(1'b0, A_RXE, 16'h0000);
      check("rxe_sat", q, 32'h0000_FFFF);
      xfer(1'b0, A_MODE, 16'h0000);
      check("full_flag", q, 32'h0000_0040);
      xfer(1'b0, A_MODE, 16'h0000);
      check("flag_clear", q, 32'h0000_0000);
      xfer(1'b1, A_RXE, 16'h0000);
      xfer(1'b0, A_RXE, 16'h0000);
      check("rxe_write", q, 32'h0000_0000);
      @(posedge core_clk);
      rst_n <= 1'b0;
      strap <= 5'b01111;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      settle;
      check("fiber_sel", fiber_mode_select, 1'b1);
      check("bypass", coding_sublayer_bypass, 1'b1);
      check("scram_on", scrambler_on, 1'b0);
      check("led_std", led_standard, 1'b0);
      check("ff_enable", far_fault_enable, 1'b0);
      xfer(1'b0, A_MODE, 16'h0000);
      check("mode_strap", q, 32'h0000_0103);
      xfer(1'b0, A_PLL, 16'h0000);
      check("pll_rst", q, 32'h0000_0000);
      tally_and_finish;
   end
endmodule
